// ---- hw/acr_config_bank.sv ----
/*
 * Serial configuration bank of a dual-channel converter: five byte
 * registers written and read over an address-byte/data-byte serial frame,
 * readback on a dedicated pin, and channel A output pattern and format.
 * Assumes serial pins come from outside clk's domain, conversion data and
 * the custom pattern come from logic on clk.
 */
`timescale 1ns/100ps
module acr_config_bank
   import acr_pkg::*;
#(
   parameter int SAMPLE_W = 12
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // serial configuration pins
   input wire logic sclk,
   input wire logic sen_n,
   input wire logic sdata,
   output logic serial_readback_pin_o,
   output logic serial_readback_pin_oe_n,
   // channel A data path
   input wire logic [SAMPLE_W-1:0] conv_data,
   input wire logic [SAMPLE_W-1:0] custom_pattern,
   output logic [SAMPLE_W-1:0] chan_a_data_r,
   // configuration fields
   output logic [5:0] swing_code,
   output logic best_perf_select,
   output logic [3:0] chan_a_gain_code,
   output logic [3:0] chan_a_gain_half_db_r,
   output logic [2:0] chan_a_pattern_select,
   output logic offset_binary
);

   initial begin
      if (SAMPLE_W != 12) begin
         $error("acr_config_bank: toggle pattern needs 12-bit samples");
      end
   end

   // ----------------------------------------------------------------
   // serial front end
   // ----------------------------------------------------------------
   logic sclk_rise;
   logic [ACR_CNT_W-1:0] bit_cnt_r;
   logic [ACR_ADDR_W-1:0] addr_r;
   logic [ACR_FRAME_BITS-2:0] shift_r;
   logic sdata_s;

   acr_serial_rx #(
      .FRAME_BITS(ACR_FRAME_BITS),
      .ADDR_W(ACR_ADDR_W)
   ) u_rx (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sclk(sclk),
      .sen_n(sen_n),
      .sdata(sdata),
      .sclk_rise(sclk_rise),
      .bit_cnt_r(bit_cnt_r),
      .addr_r(addr_r),
      .shift_r(shift_r),
      .sdata_s(sdata_s)
   );

   logic [7:0] wr_data;
   logic wr_p;
   logic wr_ok;
   logic rd_load_p;
   logic rd_shift_p;

   assign wr_data = {shift_r[ACR_DATA_W-2:0], sdata_s};
   assign wr_p = sclk_rise && bit_cnt_r == ACR_CNT_W'(ACR_FRAME_BITS - 1);
   assign rd_load_p = sclk_rise && bit_cnt_r == ACR_CNT_W'(ACR_ADDR_W);
   assign rd_shift_p = sclk_rise && bit_cnt_r > ACR_CNT_W'(ACR_ADDR_W)
      && bit_cnt_r < ACR_CNT_W'(ACR_FRAME_BITS);

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   logic [7:0] ctrl_r, swing_r, perf_r, gain_pat_r, format_r;

   // register 00h stays writable so software can leave readback mode
   assign wr_ok = wr_p && (addr_r == ACR_OFS_RESET_READBACK
      || !ctrl_r[ACR_READBACK_BIT]);

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= ACR_RESET_VAL;
         swing_r <= ACR_RESET_VAL;
         perf_r <= ACR_RESET_VAL;
         gain_pat_r <= ACR_RESET_VAL;
         format_r <= ACR_RESET_VAL;
      end else if (ce) begin
         if (ctrl_r[ACR_SOFT_RESET_BIT]) begin
            // one cycle after the request every register, the bit itself too
            ctrl_r <= ACR_RESET_VAL;
            swing_r <= ACR_RESET_VAL;
            perf_r <= ACR_RESET_VAL;
            gain_pat_r <= ACR_RESET_VAL;
            format_r <= ACR_RESET_VAL;
         end else if (wr_ok) begin
            case (addr_r)
               ACR_OFS_RESET_READBACK: ctrl_r <= wr_data & ACR_MASK_RESET_READBACK;
               ACR_OFS_SWING: swing_r <= wr_data & ACR_MASK_SWING;
               ACR_OFS_PERF: perf_r <= wr_data & ACR_MASK_PERF;
               ACR_OFS_GAIN_PAT: gain_pat_r <= wr_data & ACR_MASK_GAIN_PAT;
               ACR_OFS_FORMAT: format_r <= wr_data & ACR_MASK_FORMAT;
               default: ;
            endcase
         end
      end
   end

   function automatic logic [7:0] read_mux(input logic [7:0] a);
      case (a)
         ACR_OFS_RESET_READBACK: read_mux = ctrl_r;
         ACR_OFS_SWING: read_mux = swing_r;
         ACR_OFS_PERF: read_mux = perf_r;
         ACR_OFS_GAIN_PAT: read_mux = gain_pat_r;
         ACR_OFS_FORMAT: read_mux = format_r;
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   logic [7:0] rd_sel;
   assign rd_sel = read_mux(addr_r);

   // ----------------------------------------------------------------
   // readback shifter
   // ----------------------------------------------------------------
   // D7 stands from the ninth rising edge so the falling edge in its own
   // bit slot catches it; each later rising edge moves one bit on
   logic [7:0] rd_sh_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_sh_r <= 8'h00;
      end else if (ce) begin
         if (!ctrl_r[ACR_READBACK_BIT]) begin
            rd_sh_r <= 8'h00;
         end else if (rd_load_p) begin
            rd_sh_r <= read_mux(addr_r);
         end else if (rd_shift_p) begin
            rd_sh_r <= {rd_sh_r[6:0], 1'b0};
         end
      end
   end

   // the shifter still holds D0 for one cycle after readback is switched off
   assign serial_readback_pin_o = rd_sh_r[7] && ctrl_r[ACR_READBACK_BIT];
   assign serial_readback_pin_oe_n = !ctrl_r[ACR_READBACK_BIT];

   // ----------------------------------------------------------------
   // field outputs
   // ----------------------------------------------------------------
   // the swing code only takes effect once the far side enables the override
   assign swing_code = swing_r[ACR_SWING_LSB +: 6];
   assign best_perf_select = perf_r[1:0] == ACR_PERF_BEST;
   assign chan_a_gain_code = gain_pat_r[ACR_GAIN_LSB +: 4];
   assign chan_a_pattern_select = gain_pat_r[ACR_PAT_LSB +: 3];
   assign offset_binary = format_r[ACR_FORMAT_LSB +: 2] == ACR_FORMAT_OFFSET_BIN;

   // ----------------------------------------------------------------
   // channel A gain and data path
   // ----------------------------------------------------------------
   logic [SAMPLE_W-1:0] ramp_r;
   logic toggle_r;
   logic [SAMPLE_W-1:0] src;

   always_comb begin
      case (acr_pattern_type'(chan_a_pattern_select))
         ACR_PAT_NORMAL: src = conv_data;
         ACR_PAT_ZEROS: src = '0;
         ACR_PAT_ONES: src = '1;
         ACR_PAT_TOGGLE: src = toggle_r ? ACR_TOGGLE_B : ACR_TOGGLE_A;
         ACR_PAT_RAMP: src = ramp_r;
         ACR_PAT_CUSTOM: src = custom_pattern;
         default: src = conv_data;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ramp_r <= '0;
         toggle_r <= 1'b0;
         chan_a_data_r <= '0;
         chan_a_gain_half_db_r <= 4'h0;
      end else if (ce) begin
         ramp_r <= ramp_r + 1'b1;
         toggle_r <= !toggle_r;
         // offset binary differs from two's complement by the sign bit only
         chan_a_data_r <= offset_binary ? {!src[SAMPLE_W-1], src[SAMPLE_W-2:0]} : src;
         // code 0000 is zero gain; codes above 6 dB are undefined and fall back to it
         chan_a_gain_half_db_r <= (chan_a_gain_code > ACR_GAIN_MAX) ? 4'h0
            : chan_a_gain_code;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_soft_req;
      ce && wr_ok && addr_r == ACR_OFS_RESET_READBACK && wr_data[ACR_SOFT_RESET_BIT];
   endsequence

   sequence s_rd_load;
      ce && rd_load_p && ctrl_r[ACR_READBACK_BIT];
   endsequence

   property p_soft_reset;
      @(posedge clk) disable iff (rst)
      s_soft_req ##1 ce |=> ctrl_r == 8'h00 && swing_r == 8'h00 && perf_r == 8'h00
         && gain_pat_r == 8'h00 && format_r == 8'h00;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

   property p_self_clear;
      @(posedge clk) disable iff (rst)
      ctrl_r[ACR_SOFT_RESET_BIT] ##0 ce |=> !ctrl_r[ACR_SOFT_RESET_BIT];
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("reset bit stuck");

   property p_hiz;
      @(posedge clk) disable iff (rst)
      $fell(ctrl_r[ACR_READBACK_BIT]) |-> serial_readback_pin_oe_n && !serial_readback_pin_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("readback pin not released");

   property p_drive;
      @(posedge clk) disable iff (rst)
      ctrl_r[ACR_READBACK_BIT] |-> !serial_readback_pin_oe_n;
   endproperty
   a_drive: assert property (p_drive) else $error("readback pin not driven");

   property p_readback;
      @(posedge clk) disable iff (rst)
      s_rd_load |=> {serial_readback_pin_o, 7'h00} == ($past(rd_sel) & 8'h80);
   endproperty
   a_readback: assert property (p_readback) else $error("readback bit wrong");

   property p_write_blocked;
      @(posedge clk) disable iff (rst)
      wr_p && addr_r == ACR_OFS_GAIN_PAT && ctrl_r[ACR_READBACK_BIT]
         && !ctrl_r[ACR_SOFT_RESET_BIT] |=> $stable(gain_pat_r);
   endproperty
   a_write_blocked: assert property (p_write_blocked) else $error("write in readback");

   property p_write_only_target;
      @(posedge clk) disable iff (rst)
      ce && wr_ok && addr_r == ACR_OFS_FORMAT && !ctrl_r[ACR_SOFT_RESET_BIT]
         |=> format_r == ($past(wr_data) & ACR_MASK_FORMAT) && $stable(swing_r);
   endproperty
   a_write_only_target: assert property (p_write_only_target) else $error("write stray");

   property p_format_ones;
      @(posedge clk) disable iff (rst)
      ce && chan_a_pattern_select == 3'h2 ##1 ce
         |-> chan_a_data_r == ($past(offset_binary) ? 12'h7FF : 12'hFFF);
   endproperty
   a_format_ones: assert property (p_format_ones) else $error("pattern or format wrong");

   property p_reset_zero;
      @(posedge clk) rst |=> ctrl_r == 8'h00 && chan_a_gain_half_db_r == 4'h0 && !best_perf_select;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

endmodule : acr_config_bank

// ---- hw/acr_serial_rx.sv ----
/*
 * Serial front end: synchronises the serial clock, enable and data pins,
 * finds serial clock rising edges and counts the bits of one frame.
 * Assumes the serial clock is slower than a quarter of clk.
 */
`timescale 1ns/100ps
module acr_serial_rx
   import acr_pkg::*;
#(
   parameter int FRAME_BITS = ACR_FRAME_BITS,
   parameter int ADDR_W = ACR_ADDR_W
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // pins
   input wire logic sclk,
   input wire logic sen_n,
   input wire logic sdata,
   // frame state
   output logic sclk_rise,
   output logic [ACR_CNT_W-1:0] bit_cnt_r,
   output logic [ADDR_W-1:0] addr_r,
   output logic [FRAME_BITS-2:0] shift_r,
   output logic sdata_s
);

   initial begin
      if (FRAME_BITS != 2 * ADDR_W || FRAME_BITS >= (1 << ACR_CNT_W)) begin
         $error("acr_serial_rx: frame must be one address and one data byte");
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic sclk_m, sclk_s, sclk_d;
   logic sen_m, sen_s;
   logic sdata_m;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         sen_m <= 1'b1;
         sen_s <= 1'b1;
         sdata_m <= 1'b0;
         sdata_s <= 1'b0;
      end else if (ce) begin
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         sen_m <= sen_n;
         sen_s <= sen_m;
         sdata_m <= sdata;
         sdata_s <= sdata_m;
      end
   end

   assign sclk_rise = ce && sclk_s && !sclk_d && !sen_s;

   // ----------------------------------------------------------------
   // bit counter and shift register
   // ----------------------------------------------------------------
   // bits past the frame length are ignored until the enable is released
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt_r <= '0;
         shift_r <= '0;
         addr_r <= '0;
      end else if (ce) begin
         if (sen_s) begin
            bit_cnt_r <= '0;
         end else if (sclk_rise && bit_cnt_r != ACR_CNT_W'(FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            shift_r <= {shift_r[FRAME_BITS-3:0], sdata_s};
            if (bit_cnt_r == ACR_CNT_W'(ADDR_W - 1)) begin
               addr_r <= {shift_r[ADDR_W-2:0], sdata_s};
            end
         end
      end
   end

endmodule : acr_serial_rx

// ---- pkg/acr_pkg.sv ----
/*
 * Constants shared by the serial configuration bank: register offsets,
 * field positions, write masks, reset value, frame layout and pattern codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acr_pkg;

   // ----------------------------------------------------------------
   // serial frame layout
   // ----------------------------------------------------------------
   localparam int ACR_ADDR_W = 8;
   localparam int ACR_DATA_W = 8;
   localparam int ACR_FRAME_BITS = 16;
   localparam int ACR_CNT_W = 5;

   // ----------------------------------------------------------------
   // register offsets and reset value
   // ----------------------------------------------------------------
   localparam logic [7:0] ACR_OFS_RESET_READBACK = 8'h00;
   localparam logic [7:0] ACR_OFS_SWING = 8'h01;
   localparam logic [7:0] ACR_OFS_PERF = 8'h03;
   localparam logic [7:0] ACR_OFS_GAIN_PAT = 8'h25;
   localparam logic [7:0] ACR_OFS_FORMAT = 8'h29;
   localparam logic [7:0] ACR_RESET_VAL = 8'h00;

   // ----------------------------------------------------------------
   // field positions and the bits each register keeps
   // ----------------------------------------------------------------
   localparam int ACR_READBACK_BIT = 0;
   localparam int ACR_SOFT_RESET_BIT = 1;
   localparam int ACR_SWING_LSB = 2;
   localparam int ACR_GAIN_LSB = 4;
   localparam int ACR_PAT_LSB = 0;
   localparam int ACR_FORMAT_LSB = 3;
   localparam logic [7:0] ACR_MASK_RESET_READBACK = 8'h03;
   localparam logic [7:0] ACR_MASK_SWING = 8'hFC;
   localparam logic [7:0] ACR_MASK_PERF = 8'h03;
   localparam logic [7:0] ACR_MASK_GAIN_PAT = 8'hF7;
   localparam logic [7:0] ACR_MASK_FORMAT = 8'h18;

   // ----------------------------------------------------------------
   // field codes
   // ----------------------------------------------------------------
   localparam logic [1:0] ACR_PERF_BEST = 2'h3;
   localparam logic [1:0] ACR_FORMAT_OFFSET_BIN = 2'h3;
   localparam logic [3:0] ACR_GAIN_MAX = 4'hC;
   localparam logic [11:0] ACR_TOGGLE_A = 12'hAAA;
   localparam logic [11:0] ACR_TOGGLE_B = 12'h555;

   typedef enum logic [2:0] {
      ACR_PAT_NORMAL,
      ACR_PAT_ZEROS,
      ACR_PAT_ONES,
      ACR_PAT_TOGGLE,
      ACR_PAT_RAMP,
      ACR_PAT_CUSTOM
   } acr_pattern_type;

endpackage : acr_pkg

// ---- tb/acr_config_bank_tb.sv ----
/*
 * Self-checking bench for the serial configuration bank: register writes,
 * field decodes, channel A data path, readback and soft reset.
 * Assumes the controller model in acr_ctrl_model and the acr_pkg constants.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module acr_config_bank_tb
   import acr_pkg::*;
;
   logic clk, rst, ce, sclk, sen_n, sdata, pin_o, pin_oe_n, best, offs;
   wire rb_pin;
   logic [11:0] conv, cust, dout, prev;
   logic [5:0] swing;
   logic [3:0] gain, half;
   logic [2:0] pat;
   int n_mismatch, check_count;
   logic [5:0] swings [6] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h3E, 6'h0F};

   // ----------------------------------------------------------------
   // clock, pin resolution, instances
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   assign rb_pin = pin_oe_n ? 1'bz : pin_o;

   acr_config_bank u_acr_config_bank (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk),
      .sen_n(sen_n), .sdata(sdata), .serial_readback_pin_o(pin_o),
      .serial_readback_pin_oe_n(pin_oe_n), .conv_data(conv), .custom_pattern(cust),
      .chan_a_data_r(dout), .swing_code(swing), .best_perf_select(best),
      .chan_a_gain_code(gain), .chan_a_gain_half_db_r(half),
      .chan_a_pattern_select(pat), .offset_binary(offs));

   acr_ctrl_model u_acr_ctrl_model (.clk(clk), .sclk(sclk), .sen_n(sen_n),
      .sdata(sdata), .rb_pin(rb_pin));

   // ----------------------------------------------------------------
   // access tasks and verdict
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] junk;
      u_acr_ctrl_model.xfer(a, d, junk);
   endtask : wr

   // dummy data 01h keeps readback on when the read targets register 00h
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] got;
      u_acr_ctrl_model.xfer(a, 8'h01, got);
      `CHK(got, e)
   endtask : rd_chk

   task automatic report_and_stop;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      conv = 12'h123;
      cust = 12'h5A6;
      n_mismatch = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(pin_oe_n, 1'b1)
      `CHK({swing, best, gain, pat, offs}, 15'h0000)
      `CHK(half, 4'h0)
      foreach (swings[i]) begin
         wr(ACR_OFS_SWING, {swings[i], 2'h0});
         `CHK(swing, swings[i])
      end
      wr(ACR_OFS_PERF, 8'h03);
      `CHK(best, 1'b1)
      wr(ACR_OFS_PERF, 8'h00);
      `CHK(best, 1'b0)
      for (int f = 0; f < 4; f++) begin
         wr(ACR_OFS_FORMAT, 8'(f << 3));
         @(negedge clk);
         `CHK(offs, (f == 3))
         `CHK(dout, (f == 3) ? (conv ^ 12'h800) : conv)
      end
      wr(ACR_OFS_FORMAT, 8'h00);
      for (int g = 0; g < 13; g++) begin
         wr(ACR_OFS_GAIN_PAT, {4'(g), 4'h0});
         @(negedge clk);
         `CHK(gain, 4'(g))
         `CHK(half, 4'(g))
      end
      wr(ACR_OFS_GAIN_PAT, 8'hD0);
      @(negedge clk);
      `CHK(half, 4'h0)
      `CHK(swing, 6'h0F)
      for (int p = 0; p < 7; p++) begin
         wr(ACR_OFS_GAIN_PAT, 8'(p));
         @(negedge clk);
         prev = dout;
         @(negedge clk);
         `CHK(pat, 3'(p))
         case (p)
            0: `CHK(dout, conv)
            1: `CHK(dout, 12'h000)
            2: `CHK(dout, 12'hFFF)
            3: `CHK(dout, (prev == ACR_TOGGLE_A) ? ACR_TOGGLE_B : ACR_TOGGLE_A)
            4: `CHK(dout, prev + 12'h001)
            5: `CHK(dout, cust)
            default: `CHK(dout, conv)
         endcase
      end
      // a low clock enable must freeze the ramp and the output register
      wr(ACR_OFS_GAIN_PAT, 8'h04);
      @(negedge clk);
      ce = 1'b0;
      prev = dout;
      repeat (3) @(negedge clk);
      `CHK(dout, prev)
      ce = 1'b1;
      @(negedge clk);
      `CHK(dout, prev + 12'h001)
      wr(ACR_OFS_GAIN_PAT, 8'hA5);
      wr(ACR_OFS_RESET_READBACK, 8'h01);
      @(negedge clk);
      `CHK(pin_oe_n, 1'b0)
      rd_chk(ACR_OFS_GAIN_PAT, 8'hA5);
      wr(ACR_OFS_SWING, 8'h50);
      rd_chk(ACR_OFS_SWING, 8'h3C);
      rd_chk(8'h02, 8'h00);
      wr(ACR_OFS_RESET_READBACK, 8'h00);
      @(negedge clk);
      `CHK(pin_oe_n, 1'b1)
      wr(ACR_OFS_SWING, 8'h50);
      `CHK(swing, 6'h14)
      wr(ACR_OFS_PERF, 8'h03);
      wr(ACR_OFS_RESET_READBACK, 8'h02);
      @(negedge clk);
      `CHK({swing, best, gain, pat, offs}, 15'h0000)
      wr(ACR_OFS_RESET_READBACK, 8'h01);
      rd_chk(ACR_OFS_RESET_READBACK, 8'h01);
      wr(ACR_OFS_RESET_READBACK, 8'h00);
      report_and_stop();
   end

endmodule : acr_config_bank_tb

// ---- tb/acr_ctrl_model.sv ----
/*
 * Behavioural model of the external controller on the serial configuration
 * pins: sends address byte then data byte, captures the readback byte.
 * Assumes clk is the bank's 100 MHz clock and readback level comes resolved.
 */
`timescale 1ns/100ps
module acr_ctrl_model (
   // clock
   input wire logic clk,
   // serial pins
   output logic sclk,
   output logic sen_n,
   output logic sdata,
   input wire logic rb_pin
);

   // ----------------------------------------------------------------
   // frame timing
   // ----------------------------------------------------------------
   // six cycles a phase: the bank needs four, and readback moves ~3 after a rise
   localparam int HALF_CLKS = 6;

   initial begin
      sclk = 1'b0;
      sen_n = 1'b1;
      sdata = 1'b0;
   end

   // ----------------------------------------------------------------
   // one frame, msb first
   // ----------------------------------------------------------------
   task automatic xfer(input logic [7:0] addr, input logic [7:0] data,
                       output logic [7:0] rd);
      logic [15:0] frame;
      frame = {addr, data};
      rd = 8'h00;
      @(negedge clk);
      sen_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk);
         sdata = frame[i];
         repeat (HALF_CLKS) @(negedge clk);
         sclk = 1'b1;
         repeat (HALF_CLKS) @(negedge clk);
         if (i < 8) begin
            rd[i] = rb_pin;
         end
         sclk = 1'b0;
      end
      repeat (HALF_CLKS) @(negedge clk);
      sen_n = 1'b1;
      // deselected data line must not keep its last level
      sdata = ~sdata;
      repeat (HALF_CLKS) @(negedge clk);
   endtask : xfer

endmodule : acr_ctrl_model
